/* rtl/dpts_param_regs.sv */
// Parameter register memory: five 16-bit registers with a registered read port
`timescale 1ns/1ps
module dpts_param_regs
  import dpts_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  dpts_regs_if.mem rif // Register access
);
  logic [15:0] regs_q [DPTS_NREG];

  // Storage; the step register resets to one so a seek moves until a zero step is loaded
  generate
    for (genvar i = 0; i < DPTS_NREG; i++)
    begin : g_reg
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          regs_q[i] <= (i == 1) ? DPTS_RST_STEP : DPTS_RST_REG;
        else if (rif.wr_en && rif.wr_idx == DPTS_IDX_W'(i))
          regs_q[i] <= rif.wr_data;
      end
    end
  endgenerate

  // Registered read data
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rif.rd_data <= DPTS_RST_REG;
    else
      rif.rd_data <= regs_q[rif.rd_idx];
  end

  // Direct views that steer the sequencer
  assign rif.options = regs_q[0];
  assign rif.step = regs_q[1];
  assign rif.record_num = regs_q[2];
  assign rif.head_num = regs_q[3];
  assign rif.pattern = regs_q[4];
endmodule

/* rtl/dpts_pkg.sv */
// Package: codes, register offsets, field layouts and limits for the diagnostic panel sequencer
package dpts_pkg;
  // Parameter codes that select a register
  localparam logic [7:0] DPTS_OFS_OPTIONS = 8'h80;
  localparam logic [7:0] DPTS_OFS_STEP = 8'h81;
  localparam logic [7:0] DPTS_OFS_RECORD = 8'h83;
  localparam logic [7:0] DPTS_OFS_HEAD = 8'h85;
  localparam logic [7:0] DPTS_OFS_PATTERN = 8'h8c;
  // Command and test codes
  localparam logic [7:0] DPTS_CMD_ENTER_FTM = 8'h60;
  localparam logic [7:0] DPTS_CMD_EXIT_FTM = 8'h61;
  localparam logic [7:0] DPTS_TST_SEQ_FWD = 8'ha3;
  localparam logic [7:0] DPTS_TST_SEQ_REV = 8'ha4;
  localparam logic [7:0] DPTS_TST_SEQ_FWD_REV = 8'ha5;
  localparam logic [7:0] DPTS_TST_WRITE = 8'haa;
  localparam logic [7:0] DPTS_TST_READ = 8'hab;
  localparam logic [7:0] DPTS_TST_WRITE_READ = 8'hac;
  // Display status bytes
  localparam logic [7:0] DPTS_STS_RUNNING = 8'hf0;
  localparam logic [7:0] DPTS_STS_STOPPED = 8'hf1;
  // Field-test option bit positions (lower byte of the options register)
  localparam int DPTS_OPT_MAN_RECORD = 7;
  localparam int DPTS_OPT_MAN_HEAD = 6;
  localparam int DPTS_OPT_RND_RECORD = 5;
  localparam int DPTS_OPT_RND_HEAD = 4;
  localparam int DPTS_OPT_SINGLE = 1;
  // Engineering cylinder and drive geometry limits
  localparam logic [11:0] DPTS_CE_CYL = 12'd842;
  localparam logic [11:0] DPTS_MAX_CYL = 12'd842;
  localparam logic [7:0] DPTS_MAX_HEAD = 8'd23;
  localparam logic [7:0] DPTS_MAX_RECORD = 8'd31;
  // Reset values
  localparam logic [15:0] DPTS_RST_REG = 16'h0000;
  localparam logic [15:0] DPTS_RST_STEP = 16'h0001;
  localparam logic [15:0] DPTS_RST_LFSR = 16'hace1;
  // Register file geometry
  localparam int DPTS_NREG = 5;
  localparam int DPTS_IDX_W = 3;
  typedef logic [DPTS_IDX_W-1:0] dpts_idx_t;
  typedef enum logic [1:0] {DPTS_OP_SEEK, DPTS_OP_WRITE, DPTS_OP_READ} dpts_op_e;
endpackage

/* rtl/dpts_regs_if.sv */
// Interface: register file access between the sequencer and its parameter memory
`timescale 1ns/1ps
interface dpts_regs_if;
  import dpts_pkg::*;
  logic wr_en;
  dpts_idx_t wr_idx;
  logic [15:0] wr_data;
  dpts_idx_t rd_idx;
  logic [15:0] rd_data;
  logic [15:0] options;
  logic [15:0] step;
  logic [15:0] record_num;
  logic [15:0] head_num;
  logic [15:0] pattern;
  modport ctrl (output wr_en, wr_idx, wr_data, rd_idx, input rd_data, options, step, record_num, head_num, pattern);
  modport mem (input wr_en, wr_idx, wr_data, rd_idx, output rd_data, options, step, record_num, head_num, pattern);
endinterface

/* rtl/dpts_top.sv */
// Diagnostic panel command interpreter and field-test sequencer
// Functional notes
// R1 - Code 81 selects step register, shows it
// R2 - First load fills upper staging byte
// R3 - Second load fills lower byte, shows value
// R4 - Initiate copies staged value into register
// R5 - Loading test code shows 00 and code
// R6 - Initiate starts test, shows code F0
// R7 - A3 steps forward to max, returns, repeats
// R8 - A4 seeks max then steps back to zero
// R9 - A5 alternates forward and backward stepping
// R10 - AA writes all heads and records at 842
// R11 - AB reads all heads and records at 842
// R12 - 8C selects pattern; zero low, nonzero high
// R13 - 80 selects options: test and field-test bytes
// R14 - Option C2 sets manual record, head, single
// R15 - 83 and 85 select record and head
// R16 - Single mode: one write, then F1 shown
// R17 - Option 30 randomises; AC writes and reads
// R18 - Stopped test shows code and F1
// R19 - Tests need mode 60; 61 leaves it
// R20 - Geometry limits are fixed design constants
// R21 - Second initiate ends after current operation
`timescale 1ns/1ps
module dpts_top
  import dpts_pkg::*;
(
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [7:0] param_sw, // Parameter switches
  input wire logic load_p, // Load switch pulse
  input wire logic initiate_p, // Initiate switch pulse
  input wire logic clear_p, // Clear switch pulse
  input wire logic op_done, // Drive finished the requested operation
  output logic [15:0] display, // Four-digit hex display
  output logic op_req, // One-cycle operation request
  output logic [1:0] op_kind, // 0 seek, 1 write, 2 read
  output logic [11:0] op_cyl, // Target cylinder
  output logic [7:0] op_head, // Target head
  output logic [7:0] op_record, // Target record
  output logic pattern_high, // High-frequency data pattern selected
  output logic field_test_mode // Field-test mode active
);
  import dpts_pkg::*;

  typedef enum logic [1:0] {DPTS_ST_IDLE, DPTS_ST_ISSUE, DPTS_ST_WAIT} dpts_state_e;
  typedef enum logic [1:0] {DPTS_SEL_NONE, DPTS_SEL_REG, DPTS_SEL_TEST, DPTS_SEL_CMD} dpts_sel_e;

  logic rst_s1_q, rst_n;
  dpts_regs_if rif ();
  dpts_sel_e sel_q;
  dpts_idx_t idx_q;
  logic [1:0] nbytes_q;
  logic [15:0] stage_q;
  logic [7:0] code_q;
  dpts_state_e st_q;
  logic stop_q, dir_q, wr_phase_q;
  logic [1:0] show_rd_q;
  logic [3:0] dec_code;
  logic [11:0] cyl_q;
  logic [7:0] head_q, rec_q;
  logic [15:0] lfsr_q;
  logic single, man_rec, man_head, rnd_rec, rnd_head, last_hr;
  logic [12:0] fwd_sum;
  logic [12:0] rev_dif;

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  dpts_param_regs u_regs (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rif(rif)
  );

  // Map a parameter code to a register index; bit 3 flags a hit
  function automatic logic [3:0] reg_decode(input logic [7:0] code);
    unique case (code)
      DPTS_OFS_OPTIONS: reg_decode = 4'h8;
      DPTS_OFS_STEP: reg_decode = 4'h9;
      DPTS_OFS_RECORD: reg_decode = 4'ha;
      DPTS_OFS_HEAD: reg_decode = 4'hb;
      DPTS_OFS_PATTERN: reg_decode = 4'hc;
      default: reg_decode = 4'h0;
    endcase
  endfunction

  // True for the field-test codes this block runs
  function automatic logic is_test(input logic [7:0] code);
    is_test = (code == DPTS_TST_SEQ_FWD) || (code == DPTS_TST_SEQ_REV) ||
      (code == DPTS_TST_SEQ_FWD_REV) || (code == DPTS_TST_WRITE) ||
      (code == DPTS_TST_READ) || (code == DPTS_TST_WRITE_READ);
  endfunction

  // Option decode
  assign single = rif.options[DPTS_OPT_SINGLE]; // R14
  assign man_rec = rif.options[DPTS_OPT_MAN_RECORD]; // R14
  assign man_head = rif.options[DPTS_OPT_MAN_HEAD]; // R14
  assign rnd_rec = rif.options[DPTS_OPT_RND_RECORD]; // R17
  assign rnd_head = rif.options[DPTS_OPT_RND_HEAD]; // R17
  assign last_hr = (head_q == DPTS_MAX_HEAD) && (rec_q == DPTS_MAX_RECORD); // R20
  assign fwd_sum = {1'b0, cyl_q} + {1'b0, rif.step[11:0]};
  assign rev_dif = {1'b0, cyl_q} - {1'b0, rif.step[11:0]};
  assign rif.rd_idx = idx_q;
  // Register hit and index for the code on the switches
  assign dec_code = reg_decode(param_sw);

  // Panel decode: selection, byte staging and register writes
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_q <= DPTS_SEL_NONE;
      idx_q <= '0;
      nbytes_q <= 2'd0;
      stage_q <= DPTS_RST_REG;
      code_q <= 8'h00;
      show_rd_q <= 2'b00;
      rif.wr_en <= 1'b0;
      rif.wr_idx <= '0;
      rif.wr_data <= DPTS_RST_REG;
    end
    else
    begin
      rif.wr_en <= 1'b0;
      // Two-cycle delay: the read port needs one cycle after the index moves
      show_rd_q <= {show_rd_q[0], 1'b0};
      if (clear_p && st_q == DPTS_ST_IDLE)
      begin
        sel_q <= DPTS_SEL_NONE;
        nbytes_q <= 2'd0;
      end
      else if (load_p && st_q == DPTS_ST_IDLE)
      begin
        if (sel_q == DPTS_SEL_REG && nbytes_q == 2'd0)
        begin
          stage_q <= {param_sw, rif.rd_data[7:0]}; // R2
          nbytes_q <= 2'd1;
        end
        else if (sel_q == DPTS_SEL_REG && nbytes_q == 2'd1)
        begin
          stage_q <= {stage_q[15:8], param_sw}; // R3
          nbytes_q <= 2'd2;
        end
        else if (dec_code[3])
        begin
          sel_q <= DPTS_SEL_REG; // R1 R12 R13 R15
          idx_q <= dec_code[DPTS_IDX_W-1:0];
          nbytes_q <= 2'd0;
          show_rd_q <= 2'b01;
        end
        else
        begin
          sel_q <= is_test(param_sw) ? DPTS_SEL_TEST : DPTS_SEL_CMD; // R5
          code_q <= param_sw;
          nbytes_q <= 2'd0;
        end
      end
      else if (initiate_p && sel_q == DPTS_SEL_REG && nbytes_q == 2'd2 && st_q == DPTS_ST_IDLE)
      begin
        rif.wr_en <= 1'b1; // R4
        rif.wr_idx <= idx_q;
        rif.wr_data <= stage_q;
        nbytes_q <= 2'd0;
      end
    end
  end

  // Field-test mode entry and exit
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      field_test_mode <= 1'b0;
    else if (initiate_p && sel_q == DPTS_SEL_CMD && code_q == DPTS_CMD_ENTER_FTM)
      field_test_mode <= 1'b1; // R19
    else if (initiate_p && sel_q == DPTS_SEL_CMD && code_q == DPTS_CMD_EXIT_FTM && st_q == DPTS_ST_IDLE)
      field_test_mode <= 1'b0; // R19
  end

  // Random head and record source
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lfsr_q <= DPTS_RST_LFSR;
    else
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end

  // Test sequencer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= DPTS_ST_IDLE;
      stop_q <= 1'b0;
      dir_q <= 1'b0;
      wr_phase_q <= 1'b0;
      cyl_q <= 12'd0;
      head_q <= 8'd0;
      rec_q <= 8'd0;
      op_req <= 1'b0;
      op_kind <= DPTS_OP_SEEK;
      op_cyl <= 12'd0;
      op_head <= 8'd0;
      op_record <= 8'd0;
    end
    else
    begin
      op_req <= 1'b0;
      unique case (st_q)
        DPTS_ST_IDLE:
        begin
          if (initiate_p && sel_q == DPTS_SEL_TEST && field_test_mode) // R19
          begin
            st_q <= DPTS_ST_ISSUE; // R6
            stop_q <= 1'b0;
            wr_phase_q <= 1'b1;
            dir_q <= (code_q == DPTS_TST_SEQ_REV); // R8
            head_q <= man_head ? rif.head_num[7:0] : 8'd0; // R10 R15
            rec_q <= man_rec ? rif.record_num[7:0] : 8'd0; // R10 R15
            if (code_q == DPTS_TST_SEQ_REV)
              cyl_q <= DPTS_MAX_CYL; // R8
            else if (code_q == DPTS_TST_WRITE || code_q == DPTS_TST_READ || code_q == DPTS_TST_WRITE_READ)
              cyl_q <= DPTS_CE_CYL; // R10 R11
            else
              cyl_q <= 12'd0;
            op_kind <= DPTS_OP_SEEK;
          end
        end
        DPTS_ST_ISSUE:
        begin
          if (initiate_p)
            stop_q <= 1'b1; // R21
          op_req <= 1'b1;
          op_cyl <= cyl_q;
          op_head <= head_q;
          op_record <= rec_q;
          st_q <= DPTS_ST_WAIT;
        end
        DPTS_ST_WAIT:
        begin
          if (initiate_p)
            stop_q <= 1'b1; // R21
          if (op_done)
          begin
            st_q <= DPTS_ST_ISSUE;
            if (stop_q || initiate_p)
              st_q <= DPTS_ST_IDLE; // R21
            else if (code_q == DPTS_TST_WRITE && single && op_kind == DPTS_OP_WRITE)
              st_q <= DPTS_ST_IDLE; // R16
            unique case (code_q)
              DPTS_TST_SEQ_FWD:
                cyl_q <= (fwd_sum > {1'b0, DPTS_MAX_CYL}) ? 12'd0 : fwd_sum[11:0]; // R7
              DPTS_TST_SEQ_REV:
                cyl_q <= (cyl_q == 12'd0) ? DPTS_MAX_CYL :
                  (rev_dif[12] ? 12'd0 : rev_dif[11:0]); // R8
              DPTS_TST_SEQ_FWD_REV:
              begin
                if (!dir_q && fwd_sum >= {1'b0, DPTS_MAX_CYL})
                begin
                  cyl_q <= DPTS_MAX_CYL; // R9
                  dir_q <= 1'b1;
                end
                else if (dir_q && (rev_dif[12] || rev_dif == 13'd0))
                begin
                  cyl_q <= 12'd0; // R9
                  dir_q <= 1'b0;
                end
                else
                  cyl_q <= dir_q ? rev_dif[11:0] : fwd_sum[11:0];
              end
              DPTS_TST_WRITE_READ:
              begin
                op_kind <= wr_phase_q ? DPTS_OP_WRITE : DPTS_OP_READ; // R17
                if (!wr_phase_q)
                begin
                  head_q <= rnd_head ? (lfsr_q[7:0] % (DPTS_MAX_HEAD + 8'd1)) : head_q; // R17
                  rec_q <= rnd_rec ? (lfsr_q[15:8] % (DPTS_MAX_RECORD + 8'd1)) : rec_q; // R17
                end
                wr_phase_q <= ~wr_phase_q;
              end
              default:
              begin
                // Write or read: after the seek, walk heads and records in order
                op_kind <= (code_q == DPTS_TST_READ) ? DPTS_OP_READ : DPTS_OP_WRITE; // R10 R11
                if (op_kind != DPTS_OP_SEEK && !(single && code_q == DPTS_TST_WRITE))
                begin
                  if (last_hr)
                  begin
                    head_q <= 8'd0;
                    rec_q <= 8'd0;
                  end
                  else if (rec_q == DPTS_MAX_RECORD)
                  begin
                    rec_q <= 8'd0;
                    head_q <= head_q + 8'd1;
                  end
                  else
                    rec_q <= rec_q + 8'd1;
                end
              end
            endcase
          end
        end
        default:
          st_q <= DPTS_ST_IDLE;
      endcase
    end
  end

  // Data pattern selection follows the register's lower byte
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pattern_high <= 1'b0;
    else
      pattern_high <= (rif.pattern[7:0] != 8'h00); // R12
  end

  // Display selection
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      display <= 16'h0000;
    else if (st_q != DPTS_ST_IDLE)
      display <= {code_q, DPTS_STS_RUNNING}; // R6
    else if (show_rd_q[1])
      display <= rif.rd_data; // R1
    else if (sel_q == DPTS_SEL_REG && nbytes_q != 2'd0)
      display <= stage_q; // R2 R3 R4
    else if (load_p || clear_p)
      display <= display;
    else if (sel_q != DPTS_SEL_REG && sel_q != DPTS_SEL_NONE && display[7:0] == DPTS_STS_RUNNING)
      display <= {code_q, DPTS_STS_STOPPED}; // R16 R18
    else if (initiate_p && sel_q == DPTS_SEL_CMD)
      display <= {code_q, DPTS_STS_STOPPED};
    else if (sel_q == DPTS_SEL_TEST || sel_q == DPTS_SEL_CMD)
      display <= (display[15:8] == code_q) ? display : {8'h00, code_q}; // R5
  end

  // A started test always shows its running status within two cycles
  stat_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == DPTS_ST_IDLE ##1 st_q == DPTS_ST_ISSUE) |=> (display == {code_q, DPTS_STS_RUNNING}))
    else $error("running status not shown"); // R6
  stop_show_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == DPTS_ST_WAIT && op_done && stop_q) |=> ##1 (display == {code_q, DPTS_STS_STOPPED}))
    else $error("stopped status not shown"); // R18
  mode_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == DPTS_ST_IDLE ##1 st_q == DPTS_ST_ISSUE) |-> field_test_mode)
    else $error("test ran outside field-test mode"); // R19
  reg_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rif.wr_en && rif.wr_idx == 3'd1) |=> (rif.step == $past(rif.wr_data)))
    else $error("staged value not stored"); // R4
  // The first load after a select lands in the upper staging byte
  stage_up_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (load_p && !clear_p && st_q == DPTS_ST_IDLE && sel_q == DPTS_SEL_REG && nbytes_q == 2'd0) |=>
    (stage_q[15:8] == $past(param_sw))) else $error("upper byte not staged"); // R2
  fwd_limit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    op_req |-> op_cyl <= DPTS_MAX_CYL) else $error("seek beyond maximum cylinder"); // R7
endmodule

/* sim/dpts_drive_model.sv */
// Drive model: answers each operation request with a completion pulse
`timescale 1ns/1ps
module dpts_drive_model
(
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Reset, active low
  input wire logic op_req, // Operation request from the sequencer
  input wire logic slow, // Slow answer when high
  output logic op_done // One-cycle completion pulse
);
  int cnt_q;
  logic busy_q;
  // Count down a service time of 2 or 12 cycles, chosen by slow, then report completion
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0;
      cnt_q <= 0;
      op_done <= 1'b0;
    end
    else
    begin
      op_done <= 1'b0;
      if (op_req)
      begin
        busy_q <= 1'b1;
        cnt_q <= slow ? 12 : 2;
      end
      else if (busy_q)
      begin
        if (cnt_q == 1)
        begin
          busy_q <= 1'b0;
          op_done <= 1'b1; // Completion shows only after the service time
        end
        else
          cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule

/* sim/tb_top.sv */
// Testbench: panel switch sequences against the diagnostic sequencer
`timescale 1ns/1ps
module tb_top;
  import dpts_pkg::*;
  logic clk_sys, nrst, load_p, initiate_p, clear_p, op_done, op_req, pattern_high, field_test_mode, slow;
  logic [7:0] param_sw, op_head, op_record;
  logic [15:0] display;
  logic [1:0] op_kind;
  logic [11:0] op_cyl;
  logic [29:0] ops[$];
  logic [15:0] shad[0:4];
  int err_total, compares;
  dpts_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .param_sw(param_sw), .load_p(load_p), .initiate_p(initiate_p),
    .clear_p(clear_p), .op_done(op_done), .display(display), .op_req(op_req), .op_kind(op_kind), .op_cyl(op_cyl),
    .op_head(op_head), .op_record(op_record), .pattern_high(pattern_high), .field_test_mode(field_test_mode));
  dpts_drive_model i_drive (.clk_sys(clk_sys), .nrst(nrst), .op_req(op_req), .slow(slow), .op_done(op_done));
  // Clock at 40 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Record every operation request: kind, cylinder, head, record
  always @(posedge clk_sys)
    if (op_req === 1'b1)
      ops.push_back({op_kind, op_cyl, op_head, op_record});
  task automatic end_sim();
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One panel switch pulse: 0 load, 1 initiate, 2 clear; then let the display settle
  task automatic pulse(input logic [7:0] sw, input int which);
    @(posedge clk_sys);
    #1;
    param_sw = sw;
    load_p = (which == 0);
    initiate_p = (which == 1);
    clear_p = (which == 2);
    @(posedge clk_sys);
    #1;
    {load_p, initiate_p, clear_p} = 3'b000;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  function automatic int ridx(input logic [7:0] c);
    return (c == 8'h80) ? 0 : (c == 8'h81) ? 1 : (c == 8'h83) ? 2 : (c == 8'h85) ? 3 : 4;
  endfunction
  // Select a register, stage two bytes and transfer
  task automatic wreg(input logic [7:0] code, input logic [15:0] v);
    int k;
    k = ridx(code);
    pulse(8'h00, 2);
    pulse(code, 0);
    chk("reg_select", display, shad[k]);
    pulse(v[15:8], 0);
    chk("stage_upper", display, {v[15:8], shad[k][7:0]});
    pulse(v[7:0], 0);
    chk("stage_lower", display, v);
    pulse(8'h00, 1);
    chk("transfer", display, v);
    shad[k] = v;
  endtask
  // Select and start a test; continuous tests run n operations and are stopped
  task automatic run(input logic [7:0] code, input int n, input logic single);
    int i, sz;
    pulse(8'h00, 2);
    pulse(code, 0);
    chk("test_select", display, {8'h00, code});
    ops.delete();
    pulse(8'h00, 1);
    if (!single)
    begin
      chk("test_running", display, {code, DPTS_STS_RUNNING});
      for (i = 0; i < 3000 && ops.size() < n; i++) @(posedge clk_sys);
      pulse(8'h00, 1);
    end
    for (i = 0; i < 400 && display !== {code, DPTS_STS_STOPPED}; i++) @(posedge clk_sys);
    #1;
    chk("test_stopped", display, {code, DPTS_STS_STOPPED});
    sz = ops.size();
    repeat (30) @(posedge clk_sys);
    chk("no_op_after_stop", ops.size(), sz);
  endtask
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    logic rev;
    int wr, rd;
    nrst = 1'b0;
    {load_p, initiate_p, clear_p, slow} = 4'b0000;
    param_sw = 8'h00;
    err_total = 0;
    compares = 0;
    shad = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
    repeat (5) @(posedge clk_sys);
    #1;
    chk("reset_outputs", {display, op_req, field_test_mode}, 18'h0);
    nrst = 1'b1;
    repeat (4) @(posedge clk_sys);
    // Test refused outside field-test mode
    pulse(8'h00, 2);
    pulse(DPTS_TST_SEQ_FWD, 0);
    ops.delete();
    pulse(8'h00, 1);
    repeat (20) @(posedge clk_sys);
    chk("refused_test", ops.size(), 0);
    pulse(8'h00, 2);
    pulse(DPTS_CMD_ENTER_FTM, 0);
    pulse(8'h00, 1);
    chk("ftm_on", field_test_mode, 1'b1);
    wreg(DPTS_OFS_STEP, 16'h0006);
    run(DPTS_TST_SEQ_FWD, 4, 1'b0);
    for (int i = 2; i < 4; i++) chk("fwd_step", ops[i][27:16] - ops[i-1][27:16], 12'd6);
    chk("fwd_kind", ops[1][29:28], 2'd0);
    wreg(DPTS_OFS_STEP, 16'h00a0);
    slow = 1'b1;
    run(DPTS_TST_SEQ_REV, 3, 1'b0);
    chk("rev_first", ops[0][27:16], 12'd842);
    chk("rev_second", ops[1][27:16], 12'd682);
    slow = 1'b0;
    run(DPTS_TST_SEQ_FWD_REV, 10, 1'b0);
    rev = 1'b0;
    for (int i = 1; i < ops.size(); i++) if (ops[i][27:16] < ops[i-1][27:16]) rev = 1'b1;
    chk("fr_step", ops[2][27:16] - ops[1][27:16], 12'd160);
    chk("fr_reverse", rev, 1'b1);
    wreg(DPTS_OFS_PATTERN, 16'h0005);
    chk("pattern_hi", pattern_high, 1'b1);
    wreg(DPTS_OFS_PATTERN, 16'h0000);
    chk("pattern_lo", pattern_high, 1'b0);
    run(DPTS_TST_WRITE, 4, 1'b0);
    chk("wr_seek", ops[0], {2'd0, 12'd842, 16'h0});
    chk("wr_first", ops[1], {2'd1, 12'd842, 8'd0, 8'd0});
    chk("wr_next", ops[2], {2'd1, 12'd842, 8'd0, 8'd1});
    run(DPTS_TST_READ, 4, 1'b0);
    chk("rd_seek", ops[0], {2'd0, 12'd842, 16'h0});
    chk("rd_first", ops[1], {2'd2, 12'd842, 8'd0, 8'd0});
    chk("rd_next", ops[2], {2'd2, 12'd842, 8'd0, 8'd1});
    wreg(DPTS_OFS_OPTIONS, 16'h00c2);
    wreg(DPTS_OFS_RECORD, 16'h0015);
    wreg(DPTS_OFS_HEAD, 16'h0008);
    run(DPTS_TST_WRITE, 0, 1'b1);
    wr = 0;
    foreach (ops[i]) if (ops[i][29:28] == 2'd1) wr++;
    chk("single_count", wr, 1);
    chk("single_target", ops[ops.size()-1], {2'd1, 12'd842, 8'h08, 8'h15});
    wreg(DPTS_OFS_OPTIONS, 16'h0030);
    run(DPTS_TST_WRITE_READ, 12, 1'b0);
    wr = 0;
    rd = 0;
    foreach (ops[i])
    begin
      if (ops[i][29:28] == 2'd1) wr++;
      if (ops[i][29:28] == 2'd2) rd++;
      chk("wrrd_range", {ops[i][27:16], ops[i][15:8] <= 8'd23, ops[i][7:0] <= 8'd31}, {12'd842, 2'b11});
    end
    chk("wrrd_both", {wr > 0, rd > 0}, 2'b11);
    pulse(8'h00, 2);
    pulse(DPTS_CMD_EXIT_FTM, 0);
    pulse(8'h00, 1);
    chk("ftm_off", field_test_mode, 1'b0);
    end_sim();
  end
endmodule
